/* File: hdl/lcdcp_command_port.sv */
`timescale 1ns/1ps
module lcdcp_command_port
	import lcdcp_pkg::*;
(
	// system
	input  wire logic       mclk,
	input  wire logic       nrst,
	// two-wire bus
	input  wire logic       sclIn,
	input  wire logic       sdaIn,
	output logic            sdaOut,
	output logic            sdaOe,
	// straps
	input  wire logic       addrSelectPin,
	input  wire logic       hwSubaddrPin0,
	input  wire logic       hwSubaddrPin1,
	input  wire logic       hwSubaddrPin2,
	// display RAM write port
	output logic            ramWrEn,
	output logic [5:0]      ramAddr,
	output logic [7:0]      ramData,
	output logic            ramInBank,
	// status in system clock domain
	output logic [1:0]      driveMode,
	output logic [2:0]      subaddrCnt,
	output logic [5:0]      dataPtr,
	output logic            busBusy,
	// display refresh domain
	input  wire logic       dispClk,
	output logic            dispOutBank,
	output logic            dispBlank,
	output logic [1:0]      dispDriveMode,
	output logic            dispBias
);

	// synchronisers: stage 1 is read only by stage 2
	logic [1:0]   sclSync_reg;
	logic [1:0]   sdaSync_reg;
	logic [1:0]   selSync_reg;
	logic [2:0]   hwSync1_reg;
	logic [2:0]   hwSync2_reg;
	logic         sclPrev_reg;
	logic         sdaPrev_reg;

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			sclSync_reg <= 2'h3;
			sdaSync_reg <= 2'h3;
			selSync_reg <= 2'h0;
			hwSync1_reg <= 3'h0;
			hwSync2_reg <= 3'h0;
			sclPrev_reg <= 1'b1;
			sdaPrev_reg <= 1'b1;
		end else begin
			sclSync_reg <= {sclSync_reg[0], sclIn};
			sdaSync_reg <= {sdaSync_reg[0], sdaIn};
			selSync_reg <= {selSync_reg[0], addrSelectPin};
			hwSync1_reg <= {hwSubaddrPin2, hwSubaddrPin1, hwSubaddrPin0};
			hwSync2_reg <= hwSync1_reg;
			sclPrev_reg <= sclSync_reg[1];
			sdaPrev_reg <= sdaSync_reg[1];
		end
	end

	logic sclS;
	logic sdaS;
	logic sclRise;
	logic sclFall;
	logic startCond;
	logic stopCond;

	assign sclS      = sclSync_reg[1];
	assign sdaS      = sdaSync_reg[1];
	assign sclRise   = sclS && !sclPrev_reg;
	assign sclFall   = !sclS && sclPrev_reg;
	// the master keeps SDA steady while SCL is high, so any change there is a condition
	assign startCond = sclS && sclPrev_reg && sdaPrev_reg && !sdaS;
	assign stopCond  = sclS && sclPrev_reg && !sdaPrev_reg && sdaS;

	// byte engine
	lcdcp_state_t state_reg;
	logic [7:0]   shift_reg;
	logic [3:0]   bitCnt_reg;
	logic         ackPhase_reg;
	logic         inFrame;
	logic         byteDone;
	logic         addrMatch;
	logic         subMatch;
	logic         ackVal;

	assign inFrame  = (state_reg == ST_ADDR) || (state_reg == ST_CMD) || (state_reg == ST_DATA);
	assign byteDone = inFrame && sclFall && !ackPhase_reg && (bitCnt_reg == 4'(BIT_COUNT_BYTE));

	// a read request never matches, so the device stays silent on it
	assign addrMatch = (shift_reg[7:2] == ADDR_PREFIX)
		&& (shift_reg[ADDR_SEL_BIT] == selSync_reg[1])
		&& !shift_reg[ADDR_RW_BIT];
	assign subMatch  = (subaddrCnt == hwSync2_reg);

	always_comb begin
		case (state_reg)
			ST_ADDR: ackVal = addrMatch;
			ST_CMD:  ackVal = 1'b1;
			ST_DATA: ackVal = subMatch;
			default: ackVal = 1'b0;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			state_reg <= ST_IDLE;
		end else if (startCond) begin
			state_reg <= ST_ADDR;
		end else if (stopCond) begin
			state_reg <= ST_IDLE;
		end else if (byteDone) begin
			case (state_reg)
				ST_ADDR: begin
					state_reg <= addrMatch ? ST_CMD : ST_IGNORE;
				end
				ST_CMD: begin
					state_reg <= shift_reg[CONT_BIT] ? ST_CMD : ST_DATA;
				end
				ST_DATA: begin
					state_reg <= ST_DATA;
				end
				default: begin
					state_reg <= state_reg;
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst || startCond || stopCond) begin
			shift_reg    <= 8'h00;
			bitCnt_reg   <= 4'h0;
			ackPhase_reg <= 1'b0;
		end else if (inFrame) begin
			if (sclRise && !ackPhase_reg && (bitCnt_reg < 4'(BIT_COUNT_BYTE))) begin
				shift_reg  <= {shift_reg[6:0], sdaS};
				bitCnt_reg <= bitCnt_reg + 4'h1;
			end else if (byteDone) begin
				ackPhase_reg <= 1'b1;
			end else if (sclFall && ackPhase_reg) begin
				ackPhase_reg <= 1'b0;
				bitCnt_reg   <= 4'h0;
			end
		end
	end

	// acknowledge: pulled low from the falling edge after bit 8 to the falling edge after the ack pulse
	always_ff @(posedge mclk) begin
		if (!nrst || startCond || stopCond) begin
			sdaOe <= 1'b0;
		end else if (byteDone) begin
			sdaOe <= ackVal;
		end else if (sclFall && ackPhase_reg) begin
			sdaOe <= 1'b0;
		end
	end

	assign sdaOut  = 1'b0;
	assign busBusy = (state_reg != ST_IDLE);

	// command decoder and settings
	logic       cmdByte;
	logic       bankable;
	logic       inBank_reg;
	logic       outBank_reg;
	logic       blinkAltBank_reg;
	logic [1:0] blinkRateSel_reg;
	logic [1:0] driveMode_reg;
	logic       dispEnable_reg;
	logic       bias_reg;

	assign cmdByte  = byteDone && (state_reg == ST_CMD);
	assign bankable = (driveMode_reg == MODE_STATIC) || (driveMode_reg == MODE_MUX2);

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			inBank_reg       <= 1'b0;
			outBank_reg      <= 1'b0;
			blinkAltBank_reg <= 1'b0;
			blinkRateSel_reg <= BLINK_RATE_RST;
			driveMode_reg    <= DRIVE_MODE_RST;
			dispEnable_reg   <= 1'b0;
			bias_reg         <= 1'b0;
		end else if (cmdByte) begin
			if (shift_reg[6:2] == OP_BANKSEL) begin
				if (bankable) begin
					inBank_reg  <= shift_reg[BANK_IN_BIT];
					outBank_reg <= shift_reg[BANK_OUT_BIT];
				end
			end else if (shift_reg[6:3] == OP_BLINK) begin
				blinkAltBank_reg <= shift_reg[BLINK_ALT_BIT];
				blinkRateSel_reg <= shift_reg[1:0];
			end else if (shift_reg[6:5] == OP_MODESET) begin
				dispEnable_reg <= shift_reg[MODE_EN_BIT];
				bias_reg       <= shift_reg[MODE_BIAS_BIT];
				driveMode_reg  <= shift_reg[1:0];
			end
		end
	end

	assign driveMode = driveMode_reg;

	// data pointer and subaddress counter
	logic [6:0] ptrStep;
	logic [6:0] ptrSum;

	always_comb begin
		case (driveMode_reg)
			MODE_STATIC: ptrStep = STEP_STATIC;
			MODE_MUX2:   ptrStep = STEP_MUX2;
			MODE_MUX3:   ptrStep = STEP_MUX3;
			default:     ptrStep = STEP_MUX4;
		endcase
	end

	assign ptrSum = {1'b0, dataPtr} + ptrStep;

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			subaddrCnt <= SUBADDR_RST;
			dataPtr    <= DATA_PTR_RST;
		end else if (cmdByte) begin
			if (shift_reg[6:3] == OP_DEVSEL) begin
				subaddrCnt <= shift_reg[2:0];
			end else if (!shift_reg[LOADPTR_FLAG_BIT]) begin
				dataPtr <= shift_reg[5:0];
			end
		end else if (byteDone && (state_reg == ST_DATA)) begin
			// every device in the data state advances, whether or not its subaddress matches, so cascaded parts agree on where data lands
			if (ptrSum >= RAM_DEPTH) begin
				dataPtr    <= DATA_PTR_RST;
				subaddrCnt <= subaddrCnt + 3'h1;
			end else begin
				dataPtr <= ptrSum[5:0];
			end
		end
	end

	// display RAM write strobe
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			ramWrEn   <= 1'b0;
			ramAddr   <= 6'h00;
			ramData   <= 8'h00;
			ramInBank <= 1'b0;
		end else begin
			ramWrEn <= byteDone && (state_reg == ST_DATA) && subMatch;
			if (byteDone && (state_reg == ST_DATA)) begin
				ramAddr   <= dataPtr;
				ramData   <= shift_reg;
				ramInBank <= inBank_reg;
			end
		end
	end

	// settings word to display domain by toggle handshake; held stable while a transfer is open
	logic [7:0] setWord;
	logic [7:0] hold_reg;
	logic       reqTog_reg;
	logic [1:0] ackSync_reg;
	logic       pending;

	assign setWord = {outBank_reg, blinkAltBank_reg, blinkRateSel_reg, driveMode_reg, dispEnable_reg, bias_reg};
	assign pending = reqTog_reg != ackSync_reg[1];

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			hold_reg   <= {2'h0, BLINK_RATE_RST, DRIVE_MODE_RST, 2'h0};
			reqTog_reg <= 1'b0;
		end else if (!pending && (setWord != hold_reg)) begin
			hold_reg   <= setWord;
			reqTog_reg <= !reqTog_reg;
		end
	end

	// display domain
	logic [1:0]  dispRst_reg;
	logic [1:0]  reqSync_reg;
	logic        reqPrev_reg;
	logic        ackTog_reg;
	logic [7:0]  dispWord_reg;
	logic [11:0] blinkCnt_reg;
	logic [11:0] blinkHalf;
	logic        blinkPhase_reg;
	logic        dispRstN;
	logic        altEff;

	always_ff @(posedge dispClk) begin
		dispRst_reg <= {dispRst_reg[0], nrst};
	end

	assign dispRstN = dispRst_reg[1];

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			ackSync_reg <= 2'h0;
		end else begin
			ackSync_reg <= {ackSync_reg[0], ackTog_reg};
		end
	end

	always_ff @(posedge dispClk) begin
		if (!dispRstN) begin
			reqSync_reg  <= 2'h0;
			reqPrev_reg  <= 1'b0;
			ackTog_reg   <= 1'b0;
			dispWord_reg <= {2'h0, BLINK_RATE_RST, DRIVE_MODE_RST, 2'h0};
		end else begin
			reqSync_reg <= {reqSync_reg[0], reqTog_reg};
			reqPrev_reg <= reqSync_reg[1];
			if (reqSync_reg[1] != reqPrev_reg) begin
				dispWord_reg <= hold_reg;
				ackTog_reg   <= !ackTog_reg;
			end
		end
	end

	always_comb begin
		case (dispWord_reg[5:4])
			2'h1:    blinkHalf = BLINK_HALF_1;
			2'h2:    blinkHalf = BLINK_HALF_2;
			default: blinkHalf = BLINK_HALF_3;
		endcase
	end

	always_ff @(posedge dispClk) begin
		if (!dispRstN || (dispWord_reg[5:4] == BLINK_RATE_RST)) begin
			blinkCnt_reg   <= 12'h000;
			blinkPhase_reg <= 1'b0;
		end else if (blinkCnt_reg >= blinkHalf - 12'h001) begin
			blinkCnt_reg   <= 12'h000;
			blinkPhase_reg <= !blinkPhase_reg;
		end else begin
			blinkCnt_reg <= blinkCnt_reg + 12'h001;
		end
	end

	// no alternate bank exists in the higher multiplex modes
	assign altEff = dispWord_reg[6]
		&& ((dispWord_reg[3:2] == MODE_STATIC) || (dispWord_reg[3:2] == MODE_MUX2));

	always_ff @(posedge dispClk) begin
		if (!dispRstN) begin
			dispOutBank   <= 1'b0;
			dispBlank     <= 1'b1;
			dispDriveMode <= DRIVE_MODE_RST;
			dispBias      <= 1'b0;
		end else begin
			dispOutBank   <= dispWord_reg[7] ^ (altEff && blinkPhase_reg);
			dispBlank     <= !dispWord_reg[1] || (!altEff && blinkPhase_reg);
			dispDriveMode <= dispWord_reg[3:2];
			dispBias      <= dispWord_reg[0];
		end
	end

endmodule

/* File: hdl/lcdcp_pkg.sv */
package lcdcp_pkg;

	// address byte: fixed upper bits, then select bit, then direction bit
	localparam logic [5:0] ADDR_PREFIX      = 6'h1c;
	localparam int         ADDR_SEL_BIT     = 1;
	localparam int         ADDR_RW_BIT      = 0;

	// command byte layout
	localparam int         CONT_BIT         = 7;
	localparam logic [3:0] OP_DEVSEL        = 4'hc;
	localparam logic [4:0] OP_BANKSEL       = 5'h1e;
	localparam logic [3:0] OP_BLINK         = 4'he;
	localparam logic [1:0] OP_MODESET       = 2'h2;
	localparam int         BANK_IN_BIT      = 1;
	localparam int         BANK_OUT_BIT     = 0;
	localparam int         BLINK_ALT_BIT    = 2;
	localparam int         MODE_EN_BIT      = 3;
	localparam int         MODE_BIAS_BIT    = 2;
	localparam int         LOADPTR_FLAG_BIT = 6;

	// drive modes
	localparam logic [1:0] MODE_STATIC      = 2'h1;
	localparam logic [1:0] MODE_MUX2        = 2'h2;
	localparam logic [1:0] MODE_MUX3        = 2'h3;
	localparam logic [1:0] MODE_MUX4        = 2'h0;

	// reset values
	localparam logic [1:0] DRIVE_MODE_RST   = MODE_MUX4;
	localparam logic [2:0] SUBADDR_RST      = 3'h0;
	localparam logic [5:0] DATA_PTR_RST     = 6'h00;
	localparam logic [1:0] BLINK_RATE_RST   = 2'h0;

	// display RAM geometry and pointer step per byte in each mode
	localparam logic [6:0] RAM_DEPTH        = 7'h28;
	localparam logic [6:0] STEP_STATIC      = 7'h08;
	localparam logic [6:0] STEP_MUX2        = 7'h04;
	localparam logic [6:0] STEP_MUX3        = 7'h03;
	localparam logic [6:0] STEP_MUX4        = 7'h02;

	// blink half periods in display clock cycles (ratios 768, 1536, 3072)
	localparam logic [11:0] BLINK_HALF_1    = 12'h180;
	localparam logic [11:0] BLINK_HALF_2    = 12'h300;
	localparam logic [11:0] BLINK_HALF_3    = 12'h600;

	localparam int          BIT_COUNT_BYTE  = 8;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_CMD,
		ST_DATA,
		ST_IGNORE
	} lcdcp_state_t;

endpackage

/* File: verif/lcdcp_command_port_assertions.sv */
`timescale 1ns/1ps
module lcdcp_command_port_assertions
	import lcdcp_pkg::*;
(
	// system
	input wire logic       mclk,
	input wire logic       nrst,
	// bus
	input wire logic       sclIn,
	input wire logic       sdaIn,
	input wire logic       sdaOut,
	input wire logic       sdaOe,
	// status
	input wire logic       ramWrEn,
	input wire logic [5:0] ramAddr,
	input wire logic [1:0] driveMode,
	input wire logic [2:0] subaddrCnt,
	input wire logic [5:0] dataPtr,
	input wire logic       busBusy
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	logic [6:0] nxt;
	// pointer after a write, before the wrap at the end of RAM
	assign nxt = {1'b0, ramAddr} + (driveMode == MODE_STATIC ? STEP_STATIC : driveMode == MODE_MUX2 ? STEP_MUX2 :
		driveMode == MODE_MUX3 ? STEP_MUX3 : STEP_MUX4);
	a_ack_rise: assert property ($rose(sdaOe) |-> !sclIn)
		else $error("ack drive began with clock high");
	a_ack_held: assert property ($fell(sdaOe) |-> !sclIn)
		else $error("ack drive ended with clock high");
	a_drive_busy: assert property (sdaOe |-> busBusy)
		else $error("data line driven outside a transfer");
	a_out_low: assert property (sdaOut == 1'b0)
		else $error("data driver not low");
	a_start_seen: assert property ($fell(sdaIn) && sclIn |-> ##[1:5] busBusy)
		else $error("start not detected");
	a_stop_seen: assert property ($rose(sdaIn) && sclIn |-> ##[1:5] !busBusy)
		else $error("stop not detected");
	a_write_pulse: assert property (ramWrEn |=> !ramWrEn)
		else $error("write strobe longer than one cycle");
	a_ptr_step: assert property (ramWrEn |-> dataPtr == (nxt >= RAM_DEPTH ? 6'h00 : nxt[5:0]))
		else $error("pointer step wrong");
	a_sub_wrap: assert property (ramWrEn |-> subaddrCnt == 3'($past(subaddrCnt) + (nxt >= RAM_DEPTH)))
		else $error("subaddress advance wrong");
	a_mode_busy: assert property (!$stable(driveMode) |-> busBusy)
		else $error("drive mode changed outside a transfer");
endmodule
bind lcdcp_command_port lcdcp_command_port_assertions chk_u (.mclk, .nrst, .sclIn, .sdaIn, .sdaOut, .sdaOe,
	.ramWrEn, .ramAddr, .driveMode, .subaddrCnt, .dataPtr, .busBusy);

/* File: verif/lcdcp_bus_master.sv */
`timescale 1ns/1ps
module lcdcp_bus_master (
	// clock
	input  wire logic mclk,
	// bus
	input  wire logic sdaLine,
	output logic      sclOut,
	output logic      sdaPull
);
	initial begin
		sclOut = 1'b1;
		sdaPull = 1'b0;
	end
	// six cycles per wait step (clock high for one step, low for two in bit1) stays clear of the synchroniser delay
	task automatic wt;
		repeat (6) @(posedge mclk);
	endtask
	// data moves only while the clock is low
	task automatic bit1(input logic d, output logic r);
		sdaPull <= ~d;
		wt();
		sclOut <= 1'b1;
		wt();
		r = sdaLine;
		sclOut <= 1'b0;
		wt();
	endtask
	task automatic start;
		sdaPull <= 1'b0;
		wt();
		sclOut <= 1'b1;
		wt();
		sdaPull <= 1'b1;
		wt();
		sclOut <= 1'b0;
		wt();
	endtask
	task automatic stop;
		sdaPull <= 1'b1;
		wt();
		sclOut <= 1'b1;
		wt();
		sdaPull <= 1'b0;
		wt();
	endtask
	task automatic sendByte(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit1(b[i], r);
		bit1(1'b1, r);
		ack = !r;
	endtask
endmodule

/* File: verif/testbench.sv */
`timescale 1ns/1ps
module testbench
	import lcdcp_pkg::*;
;
	logic       mclk, nrst, dispClk, sclIn, sdaPull, sdaOut, sdaOe, ramWrEn, ramInBank, busBusy, wB, dispBlank;
	logic [2:0] subaddrCnt;
	logic [1:0] driveMode, dispDriveMode;
	logic [5:0] ramAddr, dataPtr, wA;
	logic [7:0] ramData, wD;
	int         nW = 0, n_errors = 0, n_checks = 0;
	wire        sdaLine = !(sdaPull || (sdaOe && !sdaOut));
	// command byte, then drive mode, subaddress and pointer expected after it
	logic [18:0] rows [9] = '{
		{8'h4a, 2'h2, 3'h0, 6'h00}, {8'h64, 2'h2, 3'h4, 6'h00}, {8'h05, 2'h2, 3'h4, 6'h05},
		{8'h7c, 2'h2, 3'h4, 6'h05}, {8'h77, 2'h2, 3'h4, 6'h05}, {8'h7b, 2'h2, 3'h4, 6'h05},
		{8'h4f, 2'h3, 3'h4, 6'h05}, {8'h4d, 2'h1, 3'h4, 6'h05}, {8'h4c, 2'h0, 3'h4, 6'h05}};
	logic [7:0] seqA [6] = '{8'h70, 8'he0, 8'hc9, 8'hfa, 8'h26, 8'ha5};
	logic [7:0] seqB [7] = '{8'h70, 8'hcc, 8'hf8, 8'he0, 8'h00, 8'h3c, 8'hc3};
	lcdcp_command_port dut_u (
		.mclk(mclk), .nrst(nrst), .sclIn(sclIn), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
		.addrSelectPin(1'b0), .hwSubaddrPin0(1'b0), .hwSubaddrPin1(1'b0), .hwSubaddrPin2(1'b0),
		.ramWrEn(ramWrEn), .ramAddr(ramAddr), .ramData(ramData), .ramInBank(ramInBank),
		.driveMode(driveMode), .subaddrCnt(subaddrCnt), .dataPtr(dataPtr), .busBusy(busBusy),
		.dispClk(dispClk), .dispOutBank(), .dispBlank(dispBlank), .dispDriveMode(dispDriveMode), .dispBias());
	lcdcp_bus_master m_u (.mclk(mclk), .sdaLine(sdaLine), .sclOut(sclIn), .sdaPull(sdaPull));
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	initial begin
		dispClk = 1'b0;
		#37;
		forever #80 dispClk = ~dispClk;
	end
	always @(posedge mclk) begin
		if (ramWrEn === 1'b1) begin
			wA <= ramAddr;
			wD <= ramData;
			wB <= ramInBank;
			nW <= nW + 1;
		end
	end
	task automatic report_and_stop;
		if (n_errors == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic cmp(input logic [7:0] g, input logic [7:0] e);
		n_checks++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value at %0t: got %h, expected %h", $time, g, e);
		end
	endtask
	task automatic sb(input logic [7:0] b, input logic e);
		logic a;
		m_u.sendByte(b, a);
		cmp({7'h0, a}, {7'h0, e});
	endtask
	// the display side resets from a copy of reset, so it is held over four of its clocks
	task automatic doReset;
		@(posedge mclk) nrst <= 1'b0;
		repeat (4) @(posedge dispClk);
		@(posedge mclk) nrst <= 1'b1;
		repeat (3) @(posedge mclk);
	endtask
	initial begin
		repeat (20000) @(posedge mclk);
		n_errors++;
		report_and_stop();
	end
	initial begin
		nrst = 1'b0;
		doReset();
		cmp(8'(driveMode), 8'(MODE_MUX4));
		cmp(8'(subaddrCnt), 8'h00);
		cmp({7'h0, sdaOe}, 8'h00);
		cmp({7'h0, dispBlank}, 8'h01);
		for (int i = 0; i < 9; i++) begin
			m_u.start();
			sb(8'h70, 1'b1);
			sb(rows[i][18:11], 1'b1);
			m_u.stop();
			cmp(8'(driveMode), 8'(rows[i][10:9]));
			cmp(8'(subaddrCnt), 8'(rows[i][8:6]));
			cmp(8'(dataPtr), 8'(rows[i][5:0]));
			repeat (8) @(posedge dispClk);
			cmp(8'(dispDriveMode), 8'(rows[i][10:9]));
		end
		m_u.start();
		sb(8'h72, 1'b0);
		sb(8'h60, 1'b0);
		m_u.stop();
		cmp(8'(subaddrCnt), 8'h04);
		m_u.start();
		sb(8'h71, 1'b0);
		m_u.stop();
		m_u.start();
		foreach (seqA[i]) sb(seqA[i], 1'b1);
		cmp({2'h0, wA}, 8'h26);
		cmp(wD, 8'ha5);
		cmp({7'h0, wB}, 8'h01);
		cmp({2'h0, dataPtr}, 8'h00);
		cmp(8'(subaddrCnt), 8'h01);
		sb(8'h5a, 1'b0);
		m_u.start();
		foreach (seqB[i]) sb(seqB[i], 1'b1);
		m_u.stop();
		cmp({2'h0, wA}, 8'h02);
		cmp(wD, 8'hc3);
		cmp({7'h0, wB}, 8'h01);
		cmp({2'h0, dataPtr}, 8'h04);
		cmp(8'(nW), 8'h03);
		repeat (8) @(posedge dispClk);
		cmp(8'(dispDriveMode), 8'(MODE_MUX4));
		doReset();
		cmp(8'(driveMode), 8'(MODE_MUX4));
		cmp({2'h0, dataPtr}, 8'h00);
		report_and_stop();
	end
endmodule
